/* File: pkg/rbd_pkg.sv */
// constants for the reset and boot download sequencer
`default_nettype none
package rbd_pkg;
    localparam int unsigned CLK_MHZ            = 125;
    localparam int unsigned BUSY_MAX_US        = 1055;
    localparam int unsigned ERASE_EXTRA_US     = 500;
    localparam int unsigned ADDR_STROBE_WAIT_NS = 600;
    localparam int unsigned DATA_WAIT_NS       = 660;
    // sync, hold and output edges spent outside the timed copy, with margin
    localparam int unsigned SEQ_OVERHEAD_CYCLES = 8;
    // longest times round down, least times round up
    localparam int unsigned COPY_CYCLES        = BUSY_MAX_US * CLK_MHZ - SEQ_OVERHEAD_CYCLES;
    localparam int unsigned ERASE_EXTRA_CYCLES = ERASE_EXTRA_US * CLK_MHZ;
    localparam int unsigned ADDR_STROBE_WAIT_CYCLES = (ADDR_STROBE_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DATA_WAIT_CYCLES   = (DATA_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W              = 20;
    localparam int unsigned ADDR_W             = 11;
    localparam int unsigned DATA_W             = 16;
    localparam logic        BUSY_RESET         = 1'b1;
    localparam logic        RUN_RESET          = 1'b1;

    typedef enum logic [1:0] {
        RBD_HOLD,
        RBD_COPY,
        RBD_READY,
        RBD_SLEEP
    } rbd_state_t;
endpackage
`default_nettype wire

/* File: core/rbd_sequencer.sv */
// reset release and deep power-down exit sequencer with boot copy
`timescale 1ns/1ps
`default_nettype none

module rbd_sequencer #(
    parameter int unsigned COPY_CYCLES_P  = rbd_pkg::COPY_CYCLES,
    parameter int unsigned ERASE_EXTRA_P  = rbd_pkg::ERASE_EXTRA_CYCLES,
    parameter int unsigned ADDR_W         = rbd_pkg::ADDR_W,
    parameter int unsigned DATA_W         = rbd_pkg::DATA_W
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              HARD_RESET_IN_N,
    input  wire logic              ERASE_ACTIVE,
    input  wire logic              DEEP_POWERDOWN_CTRL,
    input  wire logic              POWERDOWN_REQ,
    input  wire logic              HOST_RD,
    input  wire logic              HOST_WR,
    input  wire logic [ADDR_W-1:0] HOST_ADDR,
    input  wire logic [DATA_W-1:0] HOST_WDATA,
    input  wire logic [DATA_W-1:0] FLASH_DATA,
    output logic [ADDR_W-1:0]      FLASH_ADDR,
    output logic [DATA_W-1:0]      HOST_RDATA,
    output logic                   HOST_RVALID,
    output logic                   BUSY_N,
    output logic                   DOWNLOAD_RUNNING_BIT,
    output logic                   POWERED_DOWN
);
    import rbd_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // every control and host pin but POWERDOWN_REQ crosses two flops; DEEP_POWERDOWN_CTRL has a third flop, read with the second
    logic              rst_meta, rst_sync;
    logic              pdc_meta, pdc_sync, pdc_last;
    logic              rd_meta, rd_sync, wr_meta, wr_sync;
    logic [1:0]        erase_meta;
    logic [ADDR_W-1:0] addr_meta, addr_sync;
    logic [DATA_W-1:0] wdata_meta, wdata_sync;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= HARD_RESET_IN_N;
            rst_sync <= rst_meta;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pdc_meta <= 1'b0;
            pdc_sync <= 1'b0;
            pdc_last <= 1'b0;
        end else begin
            pdc_meta <= DEEP_POWERDOWN_CTRL;
            pdc_sync <= pdc_meta;
            pdc_last <= pdc_sync;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_meta <= 1'b0;
            rd_sync <= 1'b0;
            wr_meta <= 1'b0;
            wr_sync <= 1'b0;
        end else begin
            rd_meta <= HOST_RD;
            rd_sync <= rd_meta;
            wr_meta <= HOST_WR;
            wr_sync <= wr_meta;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            erase_meta <= 2'h0;
        end else begin
            erase_meta <= {erase_meta[0], ERASE_ACTIVE};
        end
    end

    // host holds address and data, so two flops keep them in step with the strobes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            addr_meta  <= '0;
            addr_sync  <= '0;
            wdata_meta <= '0;
            wdata_sync <= '0;
        end else begin
            addr_meta  <= HOST_ADDR;
            addr_sync  <= addr_meta;
            wdata_meta <= HOST_WDATA;
            wdata_sync <= wdata_meta;
        end
    end

    // ----------------------------------------
    // wake detect
    // ----------------------------------------
    // any edge of DEEP_POWERDOWN_CTRL while asleep wakes the device
    logic pdc_toggle;
    assign pdc_toggle = pdc_sync ^ pdc_last;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    rbd_state_t          state;
    logic [CNT_W-1:0]    count;
    logic [CNT_W-1:0]    copy_len;
    logic [DATA_W-1:0]   boot_ram [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0]   copy_ptr;
    logic                copy_done;

    // erase in flight at reset stretches the copy, still inside the bound
    assign copy_done = (count >= copy_len - 1'b1);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state    <= RBD_HOLD;
            count    <= '0;
            copy_len <= CNT_W'(COPY_CYCLES_P);
        end else if (!rst_sync) begin
            state    <= RBD_HOLD;
            count    <= '0;
            copy_len <= erase_meta[1] ? CNT_W'(COPY_CYCLES_P + ERASE_EXTRA_P)
                                      : CNT_W'(COPY_CYCLES_P);
        end else begin
            unique case (state)
                RBD_HOLD: begin
                    state <= RBD_COPY;
                    count <= '0;
                end
                RBD_COPY: begin
                    count <= count + 1'b1;
                    if (copy_done) begin
                        state <= RBD_READY;
                    end
                end
                RBD_READY: begin
                    if (POWERDOWN_REQ) begin
                        state <= RBD_SLEEP;
                    end
                end
                RBD_SLEEP: begin
                    if (pdc_toggle) begin
                        state    <= RBD_COPY;
                        count    <= '0;
                        copy_len <= CNT_W'(COPY_CYCLES_P);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // boot ram fill
    // ----------------------------------------
    // one word per cycle; ram is full long before the timed copy ends
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            copy_ptr   <= '0;
            FLASH_ADDR <= '0;
        end else if (state != RBD_COPY) begin
            copy_ptr   <= '0;
            FLASH_ADDR <= '0;
        end else begin
            FLASH_ADDR <= FLASH_ADDR + 1'b1;
            copy_ptr   <= FLASH_ADDR;
        end
    end

    always_ff @(posedge CLK) begin
        if (state == RBD_COPY && count != '0) begin
            boot_ram[copy_ptr] <= FLASH_DATA;
        end else if (state == RBD_READY && wr_sync) begin
            boot_ram[addr_sync] <= wdata_sync;
        end
    end

    // ----------------------------------------
    // host side
    // ----------------------------------------
    // a read stalled on busy is served on the same edge busy releases
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HOST_RDATA  <= '0;
            HOST_RVALID <= 1'b0;
        end else if (state == RBD_READY && rd_sync) begin
            HOST_RDATA  <= boot_ram[addr_sync];
            HOST_RVALID <= 1'b1;
        end else begin
            HOST_RVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BUSY_N               <= ~BUSY_RESET;
            DOWNLOAD_RUNNING_BIT <= RUN_RESET;
            POWERED_DOWN         <= 1'b0;
        end else begin
            BUSY_N               <= (state == RBD_READY) && rst_sync;
            DOWNLOAD_RUNNING_BIT <= !((state == RBD_READY) && rst_sync);
            POWERED_DOWN         <= (state == RBD_SLEEP);
        end
    end

endmodule
`default_nettype wire

/* File: bench/rbd_chk.sv */
// assertions on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
// ----------------
// checker
// ----------------
module rbd_chk #(
    parameter int unsigned COPY_CYCLES_P = 40,
    parameter int unsigned ERASE_EXTRA_P = 10
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HARD_RESET_IN_N,
    input wire logic DEEP_POWERDOWN_CTRL,
    input wire logic HOST_RD,
    input wire logic HOST_RVALID,
    input wire logic BUSY_N,
    input wire logic DOWNLOAD_RUNNING_BIT,
    input wire logic POWERED_DOWN
);
    localparam int LIM = COPY_CYCLES_P + ERASE_EXTRA_P + 4;
    logic [19:0] cnt;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // busy cycles since release or wake, saturating; sleep is not counted
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt <= 20'h00000;
        end else if (!BUSY_N && HARD_RESET_IN_N && !POWERED_DOWN) begin
            cnt <= (cnt == 20'hfffff) ? cnt : cnt + 20'h00001;
        end else begin
            cnt <= 20'h00000;
        end
    end
    property p_inv; DOWNLOAD_RUNNING_BIT == !BUSY_N; endproperty
    a_inv: assert property (p_inv) else $error("running bit not inverse of busy");
    property p_enter; $fell(HARD_RESET_IN_N) |-> ##[1:3] !BUSY_N; endproperty
    a_enter: assert property (p_enter) else $error("busy late on reset");
    property p_hold; !HARD_RESET_IN_N [*4] |-> !BUSY_N && !HOST_RVALID; endproperty
    a_hold: assert property (p_hold) else $error("busy dropped in reset");
    property p_refuse; !BUSY_N |-> !HOST_RVALID; endproperty
    a_refuse: assert property (p_refuse) else $error("read served while busy");
    property p_max; cnt <= LIM; endproperty
    a_max: assert property (p_max) else $error("copy too long");
    property p_min; $rose(BUSY_N) |-> cnt >= COPY_CYCLES_P; endproperty
    a_min: assert property (p_min) else $error("copy too short");
    property p_rd; $rose(HOST_RD) && BUSY_N && !POWERED_DOWN |-> ##[2:3] HOST_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_wake;
        POWERED_DOWN && $changed(DEEP_POWERDOWN_CTRL) |-> ##[1:5] !POWERED_DOWN && !BUSY_N;
    endproperty
    a_wake: assert property (p_wake) else $error("no copy on wake");
    c_done: cover property ($rose(BUSY_N));
    c_read: cover property (HOST_RVALID);
    c_wake: cover property (POWERED_DOWN && $changed(DEEP_POWERDOWN_CTRL));
    c_stall: cover property (HOST_RVALID && $rose(BUSY_N));
endmodule
`default_nettype wire

/* File: bench/rbd_flash_model.sv */
// flash array model feeding the copy
`timescale 1ns/1ps
`default_nettype none
module rbd_flash_model (
    input  wire logic                       CLK,
    input  wire logic [rbd_pkg::ADDR_W-1:0] FLASH_ADDR,
    output logic      [rbd_pkg::DATA_W-1:0] FLASH_DATA
);
    import rbd_pkg::*;
    // one cycle array latency, content is an address pattern
    always_ff @(posedge CLK) FLASH_DATA <= {FLASH_ADDR[4:0], FLASH_ADDR} ^ 16'h5a3c;
endmodule
`default_nettype wire

/* File: bench/rbd_tb.sv */
// testbench for the boot download sequencer
`timescale 1ns/1ps
`default_nettype none
module rbd_sequencer_tb;
    import rbd_pkg::*;
    localparam int unsigned CP = 40;
    localparam int unsigned EP = 10;
    logic clk = 1'b0, rst = 1'b1, pin_n = 1'b0, erase = 1'b0, pd_ctrl = 1'b0, pdreq = 1'b0;
    logic rd = 1'b0, wr = 1'b0, rvalid, busy_n, run, pd;
    logic [10:0] addr = 11'h000, faddr, ra;
    logic [15:0] wdata = 16'h0000, fdata, rdata, wval;
    logic [15:0] exp_q[$];
    int num_errors = 0, num_checks = 0, n;
    always #4 clk = ~clk;
    rbd_sequencer #(.COPY_CYCLES_P(CP), .ERASE_EXTRA_P(EP)) DUT (.CLK(clk), .RST(rst),
        .HARD_RESET_IN_N(pin_n), .ERASE_ACTIVE(erase), .DEEP_POWERDOWN_CTRL(pd_ctrl),
        .POWERDOWN_REQ(pdreq), .HOST_RD(rd), .HOST_WR(wr), .HOST_ADDR(addr),
        .HOST_WDATA(wdata), .FLASH_DATA(fdata), .FLASH_ADDR(faddr), .HOST_RDATA(rdata),
        .HOST_RVALID(rvalid), .BUSY_N(busy_n), .DOWNLOAD_RUNNING_BIT(run), .POWERED_DOWN(pd));
    rbd_flash_model FLASH (.CLK(clk), .FLASH_ADDR(faddr), .FLASH_DATA(fdata));
    // array content as the flash model holds it
    function automatic logic [15:0] pat(input logic [10:0] a);
        return {a[4:0], a} ^ 16'h5a3c;
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // strobes stop early so no read lands on the busy release
    task automatic wait_ready(output int c);
        c = 0;
        while (busy_n !== 1'b1 && c < 200) begin
            rd = (c < 20) ? 1'($urandom) : 1'b0;
            wr = (c < 20) ? 1'($urandom) : 1'b0;
            wdata = 16'($urandom);
            @(negedge clk);
            c++;
        end
        repeat (ADDR_STROBE_WAIT_CYCLES) @(negedge clk);
    endtask
    task automatic boot(input logic er);
        pin_n = 1'b0;
        erase = er;
        repeat (4) @(negedge clk);
        check("busy_in_reset", {15'h0, busy_n}, 16'h0);
        pin_n = 1'b1;
        @(negedge clk);
        erase = 1'b0;
        wait_ready(n);
        n++;
    endtask
    task automatic rd_word(input logic [10:0] a, input logic [15:0] e);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        rd = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic wr_word(input logic [10:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    // outputs settle after the rising edge, so they are looked at on the falling one
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected_read", 16'h1, 16'h0);
            else check("read_data", rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(92341));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        boot(1'b0);
        check("copy_len", 16'(n >= CP && n <= CP + 5), 16'h1);
        check("running", {15'h0, run}, 16'h0);
        repeat (4) begin
            ra = 11'($urandom_range(31, 0));
            rd_word(ra, pat(ra));
        end
        wval = 16'($urandom);
        wr_word(11'h007, wval);
        rd_word(11'h007, wval);
        boot(1'b1);
        check("erase_len", 16'(n >= CP + EP && n <= CP + EP + 5), 16'h1);
        rd_word(11'h007, pat(11'h007));
        pdreq = 1'b1;
        @(negedge clk);
        pdreq = 1'b0;
        repeat (2) @(negedge clk);
        check("sleep", {15'h0, pd}, 16'h1);
        pd_ctrl = ~pd_ctrl;
        repeat (5) @(negedge clk);
        check("wake_busy", {15'h0, busy_n}, 16'h0);
        check("wake_pd", {15'h0, pd}, 16'h0);
        // first access stalled on busy: read held until busy releases
        ra = 11'($urandom_range(31, 0));
        addr = ra;
        rd = 1'b1;
        repeat (3) exp_q.push_back(pat(ra));
        n = 5;
        while (busy_n !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        rd = 1'b0;
        check("wake_len", 16'(n >= CP && n <= CP + 5), 16'h1);
        repeat (ADDR_STROBE_WAIT_CYCLES) @(negedge clk);
        repeat (3) begin
            ra = 11'($urandom_range(31, 0));
            rd_word(ra, pat(ra));
        end
        check("reads_left", 16'(exp_q.size()), 16'h0);
        finish_test();
    end
endmodule
bind rbd_sequencer rbd_chk #(
    .COPY_CYCLES_P(COPY_CYCLES_P),
    .ERASE_EXTRA_P(ERASE_EXTRA_P)
) u_chk (
    .CLK                 (CLK),
    .RST                 (RST),
    .HARD_RESET_IN_N     (HARD_RESET_IN_N),
    .DEEP_POWERDOWN_CTRL (DEEP_POWERDOWN_CTRL),
    .HOST_RD             (HOST_RD),
    .HOST_RVALID         (HOST_RVALID),
    .BUSY_N              (BUSY_N),
    .DOWNLOAD_RUNNING_BIT(DOWNLOAD_RUNNING_BIT),
    .POWERED_DOWN        (POWERED_DOWN)
);
`default_nettype wire
